//--- ekusp_top.sv
// Fuse key/user/control security policy with Avalon-MM register access
//
// Contract
// - Key programming with the low-byte command bit also burns user low byte with the supplied pattern
// - Key burned without low-byte pattern locks user bits 7:0 until reset
// - User word is 32 bits; upper 24 burn with key or later
// - Key bank holds 256 bits, burned together with low user byte when the low-byte command bit is set
// - Control bit 0 set: only the stored key may decrypt
// - Control bit 1 set: partial reconfiguration is rejected
// - Control bit 2 set: key and user programming blocked
// - Control bit 3 set: key readback blocked
// - Control bit 4 set: user word readback blocked
// - Control write-lock bit set: control word cannot be programmed again
`timescale 1ns/100ps
`default_nettype none
module ekusp_top #(
	parameter int KEY_BITS  = ekusp_pkg::KEY_BITS,
	parameter int USER_BITS = ekusp_pkg::USER_BITS
) (
	input  wire logic        core_clk,
	input  wire logic        reset,
	input  wire logic        clk_en,
	input  wire logic [7:0]  avs_address,
	input  wire logic        avs_read,
	input  wire logic        avs_write,
	input  wire logic [31:0] avs_writedata,
	input  wire logic [3:0]  avs_byteenable,
	output logic      [31:0] avs_readdata,
	output logic             avs_waitrequest,
	input  wire logic        cfg_key_external,
	input  wire logic        cfg_partial_req,
	output logic             cfg_key_allowed,
	output logic             cfg_partial_allowed,
	output logic             busy
);
	initial if (KEY_BITS != ekusp_pkg::KEY_BITS
		|| USER_BITS != ekusp_pkg::USER_BITS)
		$error("ekusp_top: key must be 256 and user 32 bits");

	localparam int KW = ekusp_pkg::KEY_WORDS;
	localparam int LB = ekusp_pkg::USER_LOW_BITS;
	localparam int CB = ekusp_pkg::CTRL_BITS;

	// ----------------------------------------------------------------
	// Staging registers
	// ----------------------------------------------------------------
	logic [31:0]    key_stage_q [KW];
	logic [31:0]    user_stage_q;
	logic [CB-1:0]  ctrl_stage_q;
	logic           bus_ack_q;
	logic           wr_fire;
	logic           rd_fire;
	logic [31:0]    be_mask;

	assign wr_fire = clk_en && avs_write && !bus_ack_q;
	assign rd_fire = clk_en && avs_read && !bus_ack_q;
	assign be_mask = {{8{avs_byteenable[3]}}, {8{avs_byteenable[2]}},
		{8{avs_byteenable[1]}}, {8{avs_byteenable[0]}}};

	genvar gi;
	generate
		for (gi = 0; gi < KW; gi++)
		begin : g_key_stage
			always_ff @(posedge core_clk or posedge reset)
				if (reset)
					key_stage_q[gi] <= ekusp_pkg::FUSE_RESET;
				else if (wr_fire && avs_address ==
					ekusp_pkg::OFS_KEY_STAGE0 + 8'(gi * 4))
					key_stage_q[gi] <= (key_stage_q[gi] & ~be_mask)
						| (avs_writedata & be_mask);
		end
	endgenerate

	always_ff @(posedge core_clk or posedge reset)
		if (reset)
			user_stage_q <= ekusp_pkg::FUSE_RESET;
		else if (wr_fire && avs_address == ekusp_pkg::OFS_USER_STAGE)
			user_stage_q <= (user_stage_q & ~be_mask)
				| (avs_writedata & be_mask);

	always_ff @(posedge core_clk or posedge reset)
		if (reset)
			ctrl_stage_q <= '0;
		else if (wr_fire && avs_address == ekusp_pkg::OFS_CTRL_STAGE
			&& avs_byteenable[0])
			ctrl_stage_q <= avs_writedata[CB-1:0];

	// ----------------------------------------------------------------
	// Fuse banks
	// ----------------------------------------------------------------
	logic [KEY_BITS-1:0]  key_pattern;
	logic [KEY_BITS-1:0]  key_fuse;
	logic [USER_BITS-1:0] user_pattern;
	logic [USER_BITS-1:0] user_fuse;
	logic [CB-1:0]        ctrl_fuse;
	logic                 burn_key;
	logic                 burn_user;
	logic                 burn_ctrl;

	generate
		for (gi = 0; gi < KW; gi++)
		begin : g_key_pat
			assign key_pattern[gi*32 +: 32] = key_stage_q[gi];
		end
	endgenerate

	ekusp_burn #(.WIDTH(KEY_BITS)) u_key (
		.core_clk (core_clk),
		.reset    (reset),
		.clk_en   (clk_en),
		.burn     (burn_key),
		.pattern  (key_pattern),
		.fuse_q   (key_fuse)
	);

	ekusp_burn #(.WIDTH(USER_BITS)) u_user (
		.core_clk (core_clk),
		.reset    (reset),
		.clk_en   (clk_en),
		.burn     (burn_user),
		.pattern  (user_pattern),
		.fuse_q   (user_fuse)
	);

	ekusp_burn #(.WIDTH(CB)) u_ctrl (
		.core_clk (core_clk),
		.reset    (reset),
		.clk_en   (clk_en),
		.burn     (burn_ctrl),
		.pattern  (ctrl_stage_q),
		.fuse_q   (ctrl_fuse)
	);

	logic wlock_key_user;
	logic rlock_key;
	logic rlock_user;
	logic wlock_ctrl;

	ekusp_policy u_policy (
		.ctrl                (ctrl_fuse),
		.cfg_key_external    (cfg_key_external),
		.cfg_partial_req     (cfg_partial_req),
		.cfg_key_allowed     (cfg_key_allowed),
		.cfg_partial_allowed (cfg_partial_allowed),
		.wlock_key_user      (wlock_key_user),
		.rlock_key           (rlock_key),
		.rlock_user          (rlock_user),
		.wlock_ctrl          (wlock_ctrl)
	);

	// ----------------------------------------------------------------
	// Programming sequencer
	// ----------------------------------------------------------------
	ekusp_pkg::ek_state_type state_q;
	logic [3:0]  cmd_q;
	logic [3:0]  cnt_q;
	logic        low_locked_q;
	logic        refused_q;
	logic        cmd_fire;
	logic        cmd_ok;
	logic        key_req;
	logic        high_req;

	assign cmd_fire = wr_fire && avs_address == ekusp_pkg::OFS_COMMAND
		&& avs_byteenable[0];
	assign key_req  = avs_writedata[ekusp_pkg::CMD_KEY];
	assign high_req = avs_writedata[ekusp_pkg::CMD_USER_HIGH];
	// Refuse key/user ops under write lock, control op under its lock
	always_comb
	begin
		cmd_ok = state_q == ekusp_pkg::EK_IDLE;
		if ((key_req || high_req) && wlock_key_user)
			cmd_ok = 1'b0;
		if (avs_writedata[ekusp_pkg::CMD_CTRL] && wlock_ctrl)
			cmd_ok = 1'b0;
		if (!key_req && avs_writedata[ekusp_pkg::CMD_KEY_LOW])
			cmd_ok = 1'b0;
	end

	always_ff @(posedge core_clk or posedge reset)
		if (reset)
		begin
			state_q <= ekusp_pkg::EK_IDLE;
			cmd_q   <= '0;
			cnt_q   <= '0;
		end
		else if (clk_en)
			unique case (state_q)
				ekusp_pkg::EK_IDLE:
					if (cmd_fire && cmd_ok && avs_writedata[3:0] != 4'h0)
					begin
						state_q <= ekusp_pkg::EK_BURN;
						cmd_q   <= avs_writedata[3:0];
						cnt_q   <= 4'(ekusp_pkg::BURN_CYCLES - 1);
					end
				ekusp_pkg::EK_BURN:
					if (cnt_q == 4'h0)
						state_q <= ekusp_pkg::EK_DONE;
					else
						cnt_q <= cnt_q - 4'h1;
				ekusp_pkg::EK_DONE:
					state_q <= ekusp_pkg::EK_IDLE;
			endcase

	always_ff @(posedge core_clk or posedge reset)
		if (reset)
			refused_q <= 1'b0;
		else if (clk_en && cmd_fire)
			refused_q <= !cmd_ok;

	// Key burned without a low-byte pattern seals user bits 7:0
	always_ff @(posedge core_clk or posedge reset)
		if (reset)
			low_locked_q <= 1'b0;
		else if (clk_en && burn_key && !cmd_q[ekusp_pkg::CMD_KEY_LOW])
			low_locked_q <= 1'b1;

	assign burn_key  = state_q == ekusp_pkg::EK_DONE
		&& cmd_q[ekusp_pkg::CMD_KEY];
	assign burn_ctrl = state_q == ekusp_pkg::EK_DONE
		&& cmd_q[ekusp_pkg::CMD_CTRL];
	assign burn_user = burn_key || (state_q == ekusp_pkg::EK_DONE
		&& cmd_q[ekusp_pkg::CMD_USER_HIGH]);
	// Low byte only with the key and only if not sealed
	always_comb
	begin
		user_pattern = '0;
		if (cmd_q[ekusp_pkg::CMD_USER_HIGH])
			user_pattern[USER_BITS-1:LB] = user_stage_q[USER_BITS-1:LB];
		if (burn_key && cmd_q[ekusp_pkg::CMD_KEY_LOW] && !low_locked_q)
			user_pattern[LB-1:0] = user_stage_q[LB-1:0];
	end

	assign busy = state_q != ekusp_pkg::EK_IDLE;

	// ----------------------------------------------------------------
	// Avalon-MM slave: one wait cycle, then acknowledge
	// ----------------------------------------------------------------
	logic [31:0] rd_d;
	logic [31:0] rd_q;
	logic [2:0]  key_idx;

	assign key_idx = avs_address[4:2];
	always_comb
	begin
		rd_d = 32'h0000_0000;
		if (avs_address >= ekusp_pkg::OFS_KEY_STAGE0
			&& avs_address < ekusp_pkg::OFS_USER_STAGE)
			rd_d = 32'h0000_0000; // Staged key is write-only
		else if (avs_address == ekusp_pkg::OFS_USER_STAGE)
			rd_d = user_stage_q;
		else if (avs_address == ekusp_pkg::OFS_CTRL_STAGE)
			rd_d = {26'h0, ctrl_stage_q};
		else if (avs_address == ekusp_pkg::OFS_STATUS)
			rd_d = {29'h0, low_locked_q, refused_q, busy};
		else if (avs_address == ekusp_pkg::OFS_USER_FUSE)
			rd_d = rlock_user ? 32'h0000_0000 : user_fuse;
		else if (avs_address == ekusp_pkg::OFS_CTRL_FUSE)
			rd_d = {26'h0, ctrl_fuse};
		else if (avs_address >= ekusp_pkg::OFS_KEY_FUSE0
			&& avs_address < ekusp_pkg::OFS_KEY_FUSE0 + 8'h20)
			rd_d = rlock_key ? 32'h0000_0000
				: key_fuse[32*key_idx +: 32];
	end

	always_ff @(posedge core_clk or posedge reset)
		if (reset)
			rd_q <= 32'h0000_0000;
		else if (rd_fire)
			rd_q <= rd_d;

	always_ff @(posedge core_clk or posedge reset)
		if (reset)
			bus_ack_q <= 1'b0;
		else if (clk_en)
			bus_ack_q <= (avs_read || avs_write) && !bus_ack_q;

	assign avs_readdata    = rd_q;
	assign avs_waitrequest = !bus_ack_q;
endmodule
`default_nettype wire

//--- ekusp_pkg.sv
// Package: register map, control fuse bit positions and reset values
`default_nettype none
package ekusp_pkg;
	localparam int          KEY_BITS        = 256;
	localparam int          USER_BITS       = 32;
	localparam int          USER_LOW_BITS   = 8;
	localparam int          CTRL_BITS       = 6;
	localparam int          KEY_WORDS       = KEY_BITS / 32;
	// Byte offsets
	localparam logic [7:0]  OFS_KEY_STAGE0  = 8'h00; // 8 words 0x00..0x1c
	localparam logic [7:0]  OFS_USER_STAGE  = 8'h20;
	localparam logic [7:0]  OFS_CTRL_STAGE  = 8'h24;
	localparam logic [7:0]  OFS_COMMAND     = 8'h28;
	localparam logic [7:0]  OFS_STATUS      = 8'h2c;
	localparam logic [7:0]  OFS_USER_FUSE   = 8'h30;
	localparam logic [7:0]  OFS_CTRL_FUSE   = 8'h34;
	localparam logic [7:0]  OFS_KEY_FUSE0   = 8'h40; // 8 words 0x40..0x5c
	// Control fuse bit positions
	localparam int          CTL_KEY_ONLY    = 0;
	localparam int          CTL_NO_PARTIAL  = 1;
	localparam int          CTL_WLOCK_KU    = 2;
	localparam int          CTL_RLOCK_KEY   = 3;
	localparam int          CTL_RLOCK_USER  = 4;
	localparam int          CTL_WLOCK_CTL   = 5;
	// Command bits
	localparam int          CMD_KEY         = 0;
	localparam int          CMD_KEY_LOW     = 1;
	localparam int          CMD_USER_HIGH   = 2;
	localparam int          CMD_CTRL        = 3;
	// Status bits
	localparam int          ST_BUSY         = 0;
	localparam int          ST_REFUSED      = 1;
	localparam int          ST_LOW_LOCKED   = 2;
	localparam logic [31:0] FUSE_RESET      = 32'h0000_0000;
	localparam int          BURN_CYCLES     = 4;
	typedef enum logic [1:0] {EK_IDLE, EK_BURN, EK_DONE} ek_state_type;
endpackage
`default_nettype wire

//--- ekusp_burn.sv
// Fuse word burner: a burn only moves bits from 0 to 1; reset clears every bit to 0
`timescale 1ns/100ps
`default_nettype none
module ekusp_burn #(
	parameter int WIDTH = 32
) (
	input  wire logic             core_clk,
	input  wire logic             reset,
	input  wire logic             clk_en,
	input  wire logic             burn,
	input  wire logic [WIDTH-1:0] pattern,
	output logic      [WIDTH-1:0] fuse_q
);
	initial if (WIDTH < 1) $error("ekusp_burn: WIDTH must be positive");

	always_ff @(posedge core_clk or posedge reset)
		if (reset)
			fuse_q <= '0;
		else if (clk_en && burn)
			fuse_q <= fuse_q | pattern;
endmodule
`default_nettype wire

//--- ekusp_policy.sv
// Policy outputs derived from control fuses
`timescale 1ns/100ps
`default_nettype none
module ekusp_policy (
	input  wire logic [5:0] ctrl,
	input  wire logic       cfg_key_external,
	input  wire logic       cfg_partial_req,
	output logic            cfg_key_allowed,
	output logic            cfg_partial_allowed,
	output logic            wlock_key_user,
	output logic            rlock_key,
	output logic            rlock_user,
	output logic            wlock_ctrl
);
	assign cfg_key_allowed     = !(ctrl[ekusp_pkg::CTL_KEY_ONLY]
		&& cfg_key_external);
	assign cfg_partial_allowed = cfg_partial_req
		&& !ctrl[ekusp_pkg::CTL_NO_PARTIAL];
	assign wlock_key_user      = ctrl[ekusp_pkg::CTL_WLOCK_KU];
	assign rlock_key           = ctrl[ekusp_pkg::CTL_RLOCK_KEY];
	assign rlock_user          = ctrl[ekusp_pkg::CTL_RLOCK_USER];
	assign wlock_ctrl          = ctrl[ekusp_pkg::CTL_WLOCK_CTL];
endmodule
`default_nettype wire

//--- ekusp_sva.sv
// Checker: bus handshake, burn timing and policy gating
`timescale 1ns/100ps
`default_nettype none
module ekusp_sva (
	input wire logic       core_clk,
	input wire logic       reset,
	input wire logic       clk_en,
	input wire logic [7:0] avs_address,
	input wire logic       avs_read,
	input wire logic       avs_write,
	input wire logic       avs_waitrequest,
	input wire logic       cfg_key_external,
	input wire logic       cfg_partial_req,
	input wire logic       cfg_key_allowed,
	input wire logic       cfg_partial_allowed,
	input wire logic       busy
);
	// ----
	// Properties
	// ----
	default clocking @(posedge core_clk);
	endclocking
	default disable iff (reset || !clk_en);
	key_gate_a: assert property (!cfg_key_allowed |-> cfg_key_external)
		else $error("key blocked without external request");
	key_hold_a: assert property (cfg_key_external && !cfg_key_allowed
		|=> !(cfg_key_external && cfg_key_allowed)) else $error("key gate reopened");
	part_gate_a: assert property (cfg_partial_allowed |-> cfg_partial_req)
		else $error("partial allowed without request");
	part_hold_a: assert property (cfg_partial_req && !cfg_partial_allowed
		|=> !(cfg_partial_req && cfg_partial_allowed)) else $error("partial reopened");
	ack_once_a: assert property (!avs_waitrequest |=> avs_waitrequest)
		else $error("acknowledge longer than one cycle");
	ack_next_a: assert property ((avs_read || avs_write) && avs_waitrequest
		|-> ##1 !avs_waitrequest) else $error("request not answered");
	burn_len_a: assert property ($rose(busy) |-> busy[*5] ##1 !busy)
		else $error("burn length wrong");
	burn_cause_a: assert property ($rose(busy) |-> $past(avs_write)
		&& $past(avs_address) == 8'h28) else $error("burn without command");
	cover property ($rose(busy));
	cover property (cfg_key_external && !cfg_key_allowed);
	cover property (cfg_partial_req && !cfg_partial_allowed);
endmodule
bind ekusp_top ekusp_sva i_sva (.core_clk(core_clk), .reset(reset),
	.clk_en(clk_en),
	.avs_address(avs_address), .avs_read(avs_read), .avs_write(avs_write),
	.avs_waitrequest(avs_waitrequest), .cfg_key_external(cfg_key_external),
	.cfg_partial_req(cfg_partial_req), .cfg_key_allowed(cfg_key_allowed),
	.cfg_partial_allowed(cfg_partial_allowed), .busy(busy));
`default_nettype wire

//--- ekusp_host.sv
// Programming host model: Avalon-MM master
`timescale 1ns/100ps
`default_nettype none
module ekusp_host (
	input  wire logic        core_clk,
	input  wire logic [31:0] avs_readdata,
	input  wire logic        avs_waitrequest,
	output logic      [7:0]  avs_address,
	output logic             avs_read,
	output logic             avs_write,
	output logic      [31:0] avs_writedata,
	output logic      [3:0]  avs_byteenable
);
	// ----
	// Bus cycle
	// ----
	initial
	begin
		avs_address = 8'h00;
		avs_read = 1'b0;
		avs_write = 1'b0;
		avs_writedata = 32'h0;
		avs_byteenable = 4'hf;
	end
	// Held until waitrequest is low at a rising edge, for at most 16 edges
	task automatic xfer(input logic wr, input logic [7:0] a,
		input logic [31:0] d, output logic [31:0] q, output logic ok);
		int n;
		ok = 1'b0;
		q = 32'h0;
		avs_address <= a;
		avs_writedata <= d;
		avs_write <= wr;
		avs_read <= !wr;
		for (n = 0; n < 16 && !ok; n++)
		begin
			@(posedge core_clk);
			if (!avs_waitrequest)
			begin
				ok = 1'b1;
				q = avs_readdata;
			end
		end
		avs_read <= 1'b0;
		avs_write <= 1'b0;
		avs_writedata <= ~d;
		@(posedge core_clk);
	endtask
endmodule
`default_nettype wire

//--- ekusp_top_bench.sv
// Bench: fuse burning, locking and policy gating
`timescale 1ns/100ps
`default_nettype none
module ekusp_top_bench;
	logic        core_clk = 1'b0;
	logic        reset    = 1'b1;
	logic        key_ext  = 1'b0;
	logic        part_req = 1'b0;
	logic [7:0]  adr;
	logic        rd;
	logic        wr_en;
	logic [31:0] wdat;
	logic [3:0]  ben;
	logic [31:0] rdat;
	logic        wait_rq;
	logic        key_ok;
	logic        part_ok;
	logic        clk_en   = 1'b1;
	logic        bsy;
	int          mismatches  = 0;
	int          comparisons = 0;
	always #10 core_clk = ~core_clk;
	ekusp_host i_ekusp_host (.core_clk(core_clk), .avs_readdata(rdat),
		.avs_waitrequest(wait_rq), .avs_address(adr), .avs_read(rd),
		.avs_write(wr_en), .avs_writedata(wdat), .avs_byteenable(ben));
	ekusp_top i_ekusp_top (.core_clk(core_clk), .reset(reset), .clk_en(clk_en),
		.avs_address(adr), .avs_read(rd), .avs_write(wr_en),
		.avs_writedata(wdat), .avs_byteenable(ben), .avs_readdata(rdat),
		.avs_waitrequest(wait_rq), .cfg_key_external(key_ext),
		.cfg_partial_req(part_req), .cfg_key_allowed(key_ok),
		.cfg_partial_allowed(part_ok), .busy(bsy));
	// ----
	// Shared tasks
	// ----
	task automatic end_of_test();
		if (mismatches == 0 && comparisons > 0)
			$display("No errors found");
		else
			$display("Errors were found");
		$finish;
	endtask
	task automatic chk(input string what, input logic [31:0] seen, exp);
		comparisons++;
		if (seen !== exp)
		begin
			mismatches++;
			$display("[FAIL] %s expected %h seen %h", what, exp, seen);
		end
	endtask
	task automatic bus(input logic w, input logic [7:0] a,
		input logic [31:0] d, output logic [31:0] q);
		logic ok;
		i_ekusp_host.xfer(w, a, d, q, ok);
		chk("bus answer", {31'h0, ok}, 32'h1);
		if (ok !== 1'b1)
			end_of_test();
	endtask
	task automatic wr(input logic [7:0] a, input logic [31:0] d);
		logic [31:0] q;
		bus(1'b1, a, d, q);
	endtask
	task automatic exp_rd(input string w, input logic [7:0] a, logic [31:0] e);
		logic [31:0] q;
		bus(1'b0, a, 32'h0, q);
		chk(w, q, e);
	endtask
	task automatic cmd(input logic [31:0] c);
		logic [31:0] q;
		int          n;
		wr(8'h28, c);
		q = 32'h1;
		for (n = 0; n < 20 && q[0] !== 1'b0; n++)
			bus(1'b0, 8'h2c, 32'h0, q);
		if (q[0] !== 1'b0)
		begin
			mismatches++;
			end_of_test();
		end
	endtask
	task automatic restart();
		reset <= 1'b1;
		repeat (2) @(posedge core_clk);
		reset <= 1'b0;
		@(posedge core_clk);
	endtask
	task automatic key_burn(input logic [31:0] user, c);
		for (int i = 0; i < 8; i++)
			wr(8'(4 * i), 32'h5a5a_0000 + 32'(i));
		wr(8'h20, user);
		cmd(c);
	endtask
	// ----
	// Scenarios
	// ----
	task automatic t_reset();
		restart();
		exp_rd("user fuse", 8'h30, 32'h0);
		exp_rd("ctrl fuse", 8'h34, 32'h0);
		wr(8'h60, 32'hffff_ffff);
		exp_rd("unmapped", 8'h60, 32'h0);
		key_ext <= 1'b1;
		part_req <= 1'b1;
		exp_rd("status", 8'h2c, 32'h0);
		chk("key allowed", {31'h0, key_ok}, 32'h1);
		chk("partial allowed", {31'h0, part_ok}, 32'h1);
	endtask
	task automatic t_key_low();
		restart();
		cmd(32'h2);
		exp_rd("status", 8'h2c, 32'h2);
		key_burn(32'h1234_56a5, 32'h3);
		for (int i = 0; i < 8; i++)
			exp_rd("key", 8'(64 + 4 * i), 32'h5a5a_0000 + 32'(i));
		exp_rd("user fuse", 8'h30, 32'h0000_00a5);
		wr(8'h20, 32'hffff_ff00);
		cmd(32'h4);
		exp_rd("user fuse", 8'h30, 32'hffff_ffa5);
		wr(8'h20, 32'h0000_0100);
		cmd(32'h4);
		exp_rd("user fuse", 8'h30, 32'hffff_ffa5);
	endtask
	task automatic t_low_lock();
		restart();
		key_burn(32'h0000_00a5, 32'h1);
		exp_rd("status", 8'h2c, 32'h4);
		cmd(32'h3);
		exp_rd("user fuse", 8'h30, 32'h0);
	endtask
	task automatic t_ctrl();
		restart();
		key_burn(32'h0000_00a5, 32'h3);
		wr(8'h24, 32'h03);
		cmd(32'h8);
		exp_rd("ctrl fuse", 8'h34, 32'h3);
		chk("key allowed", {31'h0, key_ok}, 32'h0);
		chk("partial allowed", {31'h0, part_ok}, 32'h0);
		key_ext <= 1'b0;
		exp_rd("status", 8'h2c, 32'h0);
		chk("key allowed", {31'h0, key_ok}, 32'h1);
		wr(8'h24, 32'h20);
		cmd(32'h8);
		wr(8'h24, 32'h1c);
		cmd(32'h8);
		exp_rd("status", 8'h2c, 32'h2);
		exp_rd("ctrl fuse", 8'h34, 32'h23);
		exp_rd("user fuse", 8'h30, 32'ha5);
	endtask
	task automatic t_lock();
		restart();
		key_burn(32'h0000_00a5, 32'h3);
		wr(8'h24, 32'h1c);
		cmd(32'h8);
		exp_rd("key", 8'h40, 32'h0);
		exp_rd("user fuse", 8'h30, 32'h0);
		wr(8'h20, 32'hffff_ff00);
		cmd(32'h4);
		exp_rd("status", 8'h2c, 32'h2);
		cmd(32'h3);
		exp_rd("status", 8'h2c, 32'h2);
		exp_rd("ctrl fuse", 8'h34, 32'h1c);
	endtask
	task automatic t_freeze();
		restart();
		wr(8'h28, 32'h1);
		chk("busy", {31'h0, bsy}, 32'h1);
		clk_en <= 1'b0;
		repeat (10) @(posedge core_clk);
		chk("busy frozen", {31'h0, bsy}, 32'h1);
		clk_en <= 1'b1;
		repeat (8) @(posedge core_clk);
		chk("busy done", {31'h0, bsy}, 32'h0);
		exp_rd("status", 8'h2c, 32'h4);
	endtask
	initial
	begin
		t_reset();
		t_freeze();
		t_key_low();
		t_low_lock();
		t_ctrl();
		t_lock();
		end_of_test();
	end
endmodule
`default_nettype wire
